//--- rtl/tpg_gpio.v
// The plain strobed port was decided locally.
`include "tpg_regs.vh"

// Behaviour
// RULE1 - Drive pin from latch when enabled, not alternate
// RULE2 - Latch keeps written value while driver off
// RULE3 - Pin-level read returns live pins always
// RULE4 - Enable bit one turns the pin driver on
// RULE5 - Alternate select overrides the enable bit
// RULE6 - Three read/write output latches, reset zero
// RULE7 - Pin-level registers read-only, writes ignored
// RULE8 - Read/write drive-enable registers per port
// RULE9 - Select zero keeps GPIO, one routes peripheral
module tpg_gpio (
  input  wire                     clk_i,
  input  wire                     sys_rst_i,
  input  wire [`TPG_ADDR_W-1:0]   addr_i,
  input  wire [`TPG_DATA_W-1:0]   wdata_i,
  input  wire                     wr_i,
  input  wire                     rd_i,
  output reg  [`TPG_DATA_W-1:0]   rdata_o,
  input  wire [7:0]               port_a_pin_i,
  input  wire [7:0]               port_b_pin_i,
  input  wire [7:0]               port_c_pin_i,
  output reg  [7:0]               port_a_pin_o,
  output reg  [7:0]               port_b_pin_o,
  output reg  [7:0]               port_c_pin_o,
  output reg  [7:0]               port_a_pin_oe_o,
  output reg  [7:0]               port_b_pin_oe_o,
  output reg  [7:0]               port_c_pin_oe_o,
  input  wire [7:0]               port_a_alt_out_i,
  input  wire [7:0]               port_b_alt_out_i,
  input  wire [7:0]               port_c_alt_out_i,
  input  wire [7:0]               port_a_alt_oe_i,
  input  wire [7:0]               port_b_alt_oe_i,
  input  wire [7:0]               port_c_alt_oe_i
);

  // --------------------------------------------------------------------------
  // Software-visible state and next-value signals
  // --------------------------------------------------------------------------
  reg  [7:0] port_a_output_latch_q;
  reg  [7:0] port_b_output_latch_q;
  reg  [7:0] port_c_output_latch_q;
  reg  [7:0] port_a_drive_enable_q;
  reg  [7:0] port_b_drive_enable_q;
  reg  [7:0] port_c_drive_enable_q;
  reg  [7:0] port_a_alt_sel_q;
  reg  [7:0] port_b_alt_sel_q;
  reg  [7:0] port_c_alt_sel_q;
  reg  [7:0] rdata_d;
  reg  [7:0] port_a_pin_d;
  reg  [7:0] port_b_pin_d;
  reg  [7:0] port_c_pin_d;
  reg  [7:0] port_a_pin_oe_d;
  reg  [7:0] port_b_pin_oe_d;
  reg  [7:0] port_c_pin_oe_d;

  // --------------------------------------------------------------------------
  // Pin steering helpers
  // --------------------------------------------------------------------------
  // Per pin: alternate select picks the peripheral, otherwise the latch.
  function [7:0] pin_value;
    input [7:0] sel;
    input [7:0] latch;
    input [7:0] alt;
    begin
      pin_value = (sel & alt) | (~sel & latch); // [RULE1] [RULE9]
    end
  endfunction

  // Per pin: the enable bit only counts while the pin is in GPIO use.
  function [7:0] pin_enable;
    input [7:0] sel;
    input [7:0] en;
    input [7:0] alt_en;
    begin
      pin_enable = (sel & alt_en) | (~sel & en); // [RULE4] [RULE5] [RULE9]
    end
  endfunction

  // --------------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------------
  // One strobe qualified by one exact address; pin-level and unmapped
  // addresses get no enable, so writes to them fall away.
  // The bus never waits, so each enable lasts exactly one cycle.
  function strobe_hit;
    input                   strobe;
    input [`TPG_ADDR_W-1:0] addr;
    input [`TPG_ADDR_W-1:0] target;
    begin
      strobe_hit = strobe & (addr == target); // [RULE7]
    end
  endfunction

  wire port_a_latch_we = strobe_hit(wr_i, addr_i, `TPG_ADDR_A_OUT_LATCH);
  wire port_b_latch_we = strobe_hit(wr_i, addr_i, `TPG_ADDR_B_OUT_LATCH);
  wire port_c_latch_we = strobe_hit(wr_i, addr_i, `TPG_ADDR_C_OUT_LATCH);
  wire port_a_en_we    = strobe_hit(wr_i, addr_i, `TPG_ADDR_A_DRIVE_EN);
  wire port_b_en_we    = strobe_hit(wr_i, addr_i, `TPG_ADDR_B_DRIVE_EN);
  wire port_c_en_we    = strobe_hit(wr_i, addr_i, `TPG_ADDR_C_DRIVE_EN);
  wire port_a_sel_we   = strobe_hit(wr_i, addr_i, `TPG_ADDR_A_ALT_SEL);
  wire port_b_sel_we   = strobe_hit(wr_i, addr_i, `TPG_ADDR_B_ALT_SEL);
  wire port_c_sel_we   = strobe_hit(wr_i, addr_i, `TPG_ADDR_C_ALT_SEL);

  // --------------------------------------------------------------------------
  // Port A registers
  // --------------------------------------------------------------------------
  // Latches are written regardless of the enable so that software can
  // preload a level before turning the driver on, avoiding a glitch.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      port_a_output_latch_q <= `TPG_RST_OUT_LATCH; // [RULE6]
    else if (port_a_latch_we)
      port_a_output_latch_q <= wdata_i; // [RULE2] [RULE6]
  end

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      port_a_drive_enable_q <= `TPG_RST_DRIVE_EN;
    else if (port_a_en_we)
      port_a_drive_enable_q <= wdata_i; // [RULE8]
  end

  // The select takes the pin over one edge after the register is written, whatever the enable.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      port_a_alt_sel_q <= `TPG_RST_ALT_SEL;
    else if (port_a_sel_we)
      port_a_alt_sel_q <= wdata_i; // [RULE9]
  end

  // --------------------------------------------------------------------------
  // Port B registers
  // --------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      port_b_output_latch_q <= `TPG_RST_OUT_LATCH; // [RULE6]
    else if (port_b_latch_we)
      port_b_output_latch_q <= wdata_i; // [RULE2] [RULE6]
  end

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      port_b_drive_enable_q <= `TPG_RST_DRIVE_EN;
    else if (port_b_en_we)
      port_b_drive_enable_q <= wdata_i; // [RULE8]
  end

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      port_b_alt_sel_q <= `TPG_RST_ALT_SEL;
    else if (port_b_sel_we)
      port_b_alt_sel_q <= wdata_i; // [RULE9]
  end

  // --------------------------------------------------------------------------
  // Port C registers
  // --------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      port_c_output_latch_q <= `TPG_RST_OUT_LATCH; // [RULE6]
    else if (port_c_latch_we)
      port_c_output_latch_q <= wdata_i; // [RULE2] [RULE6]
  end

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      port_c_drive_enable_q <= `TPG_RST_DRIVE_EN;
    else if (port_c_en_we)
      port_c_drive_enable_q <= wdata_i; // [RULE8]
  end

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      port_c_alt_sel_q <= `TPG_RST_ALT_SEL;
    else if (port_c_sel_we)
      port_c_alt_sel_q <= wdata_i; // [RULE9]
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  always @*
  begin
    case (addr_i)
      `TPG_ADDR_A_OUT_LATCH:  rdata_d = port_a_output_latch_q;
      `TPG_ADDR_B_OUT_LATCH:  rdata_d = port_b_output_latch_q;
      `TPG_ADDR_C_OUT_LATCH:  rdata_d = port_c_output_latch_q;
      `TPG_ADDR_A_PIN_LEVELS: rdata_d = port_a_pin_i; // [RULE3] [RULE7]
      `TPG_ADDR_B_PIN_LEVELS: rdata_d = port_b_pin_i; // [RULE3] [RULE7]
      `TPG_ADDR_C_PIN_LEVELS: rdata_d = port_c_pin_i; // [RULE3] [RULE7]
      `TPG_ADDR_A_DRIVE_EN:   rdata_d = port_a_drive_enable_q;
      `TPG_ADDR_B_DRIVE_EN:   rdata_d = port_b_drive_enable_q;
      `TPG_ADDR_C_DRIVE_EN:   rdata_d = port_c_drive_enable_q;
      `TPG_ADDR_A_ALT_SEL:    rdata_d = port_a_alt_sel_q;
      `TPG_ADDR_B_ALT_SEL:    rdata_d = port_b_alt_sel_q;
      `TPG_ADDR_C_ALT_SEL:    rdata_d = port_c_alt_sel_q;
      default:                rdata_d = `TPG_RD_UNMAPPED;
    endcase
  end

  // Read data stands only in the cycle after the strobe; zero otherwise.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      rdata_o <= `TPG_RD_UNMAPPED;
    else if (rd_i)
      rdata_o <= rdata_d;
    else
      rdata_o <= `TPG_RD_UNMAPPED;
  end

  // --------------------------------------------------------------------------
  // Port A pin driver
  // --------------------------------------------------------------------------
  // Registered so every output comes from a flop; pins follow the
  // registers and the peripheral signals one cycle late.
  always @*
  begin
    port_a_pin_d    = pin_value(port_a_alt_sel_q, port_a_output_latch_q,
                                port_a_alt_out_i); // [RULE1]
    port_a_pin_oe_d = pin_enable(port_a_alt_sel_q, port_a_drive_enable_q,
                                 port_a_alt_oe_i); // [RULE4] [RULE5]
  end

  // Reset mirrors the register reset values: GPIO use, latch low and
  // driver off, so no pin is driven before software has set it up.
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      port_a_pin_o    <= `TPG_RST_OUT_LATCH;
      port_a_pin_oe_o <= `TPG_RST_DRIVE_EN;
    end
    else
    begin
      port_a_pin_o    <= port_a_pin_d; // [RULE1]
      port_a_pin_oe_o <= port_a_pin_oe_d; // [RULE2] [RULE4] [RULE5]
    end
  end

  // --------------------------------------------------------------------------
  // Port B pin driver
  // --------------------------------------------------------------------------
  always @*
  begin
    port_b_pin_d    = pin_value(port_b_alt_sel_q, port_b_output_latch_q,
                                port_b_alt_out_i); // [RULE1]
    port_b_pin_oe_d = pin_enable(port_b_alt_sel_q, port_b_drive_enable_q,
                                 port_b_alt_oe_i); // [RULE4] [RULE5]
  end

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      port_b_pin_o    <= `TPG_RST_OUT_LATCH;
      port_b_pin_oe_o <= `TPG_RST_DRIVE_EN;
    end
    else
    begin
      port_b_pin_o    <= port_b_pin_d; // [RULE1]
      port_b_pin_oe_o <= port_b_pin_oe_d; // [RULE2] [RULE4] [RULE5]
    end
  end

  // --------------------------------------------------------------------------
  // Port C pin driver
  // --------------------------------------------------------------------------
  always @*
  begin
    port_c_pin_d    = pin_value(port_c_alt_sel_q, port_c_output_latch_q,
                                port_c_alt_out_i); // [RULE1]
    port_c_pin_oe_d = pin_enable(port_c_alt_sel_q, port_c_drive_enable_q,
                                 port_c_alt_oe_i); // [RULE4] [RULE5]
  end

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      port_c_pin_o    <= `TPG_RST_OUT_LATCH;
      port_c_pin_oe_o <= `TPG_RST_DRIVE_EN;
    end
    else
    begin
      port_c_pin_o    <= port_c_pin_d; // [RULE1]
      port_c_pin_oe_o <= port_c_pin_oe_d; // [RULE2] [RULE4] [RULE5]
    end
  end

endmodule // tpg_gpio

//--- inc/tpg_regs.vh
`ifndef TPG_REGS_VH
`define TPG_REGS_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define TPG_ADDR_W             16
`define TPG_DATA_W             8
`define TPG_ADDR_A_ALT_SEL     16'h7F93
`define TPG_ADDR_B_ALT_SEL     16'h7F94
`define TPG_ADDR_C_ALT_SEL     16'h7F95
`define TPG_ADDR_A_OUT_LATCH   16'h7F96
`define TPG_ADDR_B_OUT_LATCH   16'h7F97
`define TPG_ADDR_C_OUT_LATCH   16'h7F98
`define TPG_ADDR_A_PIN_LEVELS  16'h7F99
`define TPG_ADDR_B_PIN_LEVELS  16'h7F9A
`define TPG_ADDR_C_PIN_LEVELS  16'h7F9B
`define TPG_ADDR_A_DRIVE_EN    16'h7F9C
`define TPG_ADDR_B_DRIVE_EN    16'h7F9D
`define TPG_ADDR_C_DRIVE_EN    16'h7F9E

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TPG_RST_OUT_LATCH      8'h00
`define TPG_RST_DRIVE_EN       8'h00
`define TPG_RST_ALT_SEL        8'h00
`define TPG_RD_UNMAPPED        8'h00

`endif

//--- verification/tpg_gpio_sva.sv
`include "tpg_regs.vh"
module tpg_gpio_sva (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic [7:0]  port_a_pin_i,
  input wire logic [7:0]  port_b_pin_i,
  input wire logic [7:0]  port_c_pin_i,
  input wire logic [7:0]  port_a_pin_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00) else $error("idle");
  a_pins_a: assert property (rd_i && addr_i == `TPG_ADDR_A_PIN_LEVELS |=>
    rdata_o == $past(port_a_pin_i)) else $error("pins a");
  a_pins_b: assert property (rd_i && addr_i == `TPG_ADDR_B_PIN_LEVELS |=>
    rdata_o == $past(port_b_pin_i)) else $error("pins b");
  a_pins_c: assert property (rd_i && addr_i == `TPG_ADDR_C_PIN_LEVELS |=>
    rdata_o == $past(port_c_pin_i)) else $error("pins c");
  a_latch_a: assert property (wr_i && addr_i == `TPG_ADDR_A_OUT_LATCH ##1 !wr_i ##1
    rd_i && addr_i == `TPG_ADDR_A_OUT_LATCH |=> rdata_o == $past(wdata_i, 3)) else $error("la");
  a_latch_b: assert property (wr_i && addr_i == `TPG_ADDR_B_OUT_LATCH ##1 !wr_i ##1
    rd_i && addr_i == `TPG_ADDR_B_OUT_LATCH |=> rdata_o == $past(wdata_i, 3)) else $error("lb");
  a_enable_back: assert property (wr_i && addr_i == `TPG_ADDR_B_DRIVE_EN ##1 !wr_i ##1
    rd_i && addr_i == `TPG_ADDR_B_DRIVE_EN |=> rdata_o == $past(wdata_i, 3)) else $error("oe");
  a_enable_reset: assert property ($fell(sys_rst_i) |-> port_a_pin_oe_o == 8'h00)
    else $error("oe reset");
  c_pin_read: cover property (rd_i && addr_i == `TPG_ADDR_A_PIN_LEVELS);
  c_drive_on: cover property (port_a_pin_oe_o != 8'h00);
  c_write_read: cover property (wr_i ##2 rd_i);
endmodule // tpg_gpio_sva
bind tpg_gpio tpg_gpio_sva u_sva (.*);

//--- verification/tpg_board.sv
module tpg_board (
  input  wire logic       clk_i,
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  output wire logic [7:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q = 8'h00;
  // No pull resistors: a released pin shows the inverse of its last driven
  // level, so a stale value can never pass for a live one.
  always @(posedge clk_i)
    last_q <= (oe_i & drv_i) | (~oe_i & last_q);
  assign lvl_o = (oe_i & drv_i) | (~oe_i & ~last_q);
endmodule // tpg_board

//--- verification/three_port_gpio_block_test.sv
`include "tpg_regs.vh"
module three_port_gpio_block_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  rdata_o;
  wire  [7:0]  pi [3];
  wire  [7:0]  po [3];
  wire  [7:0]  oe [3];
  logic [7:0]  ao [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0]  ae [3] = '{8'h00, 8'h00, 8'h00};
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  tpg_gpio DUT (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .port_a_pin_i(pi[0]), .port_b_pin_i(pi[1]), .port_c_pin_i(pi[2]),
    .port_a_pin_o(po[0]), .port_b_pin_o(po[1]), .port_c_pin_o(po[2]),
    .port_a_pin_oe_o(oe[0]), .port_b_pin_oe_o(oe[1]), .port_c_pin_oe_o(oe[2]),
    .port_a_alt_out_i(ao[0]), .port_b_alt_out_i(ao[1]), .port_c_alt_out_i(ao[2]),
    .port_a_alt_oe_i(ae[0]), .port_b_alt_oe_i(ae[1]), .port_c_alt_oe_i(ae[2]));
  for (genvar p = 0; p < 3; p++)
  begin : g_board
    tpg_board u_board (.clk_i, .drv_i(po[p]), .oe_i(oe[p]), .lvl_o(pi[p]));
  end
  initial
    forever #5 clk_i = ~clk_i;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Only bits under mask m are compared; pins nobody drives are left out.
  task automatic rc(input logic [15:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    check(rdata_o & m, exp & m);
  endtask
  task automatic t_reset();
    for (bit [15:0] p = 0; p < 3; p++)
    begin
      rc(`TPG_ADDR_A_OUT_LATCH + p, 8'h00, 8'hFF);
      check(oe[p], 8'h00);
    end
  endtask
  task automatic t_gpio();
    for (bit [15:0] p = 0; p < 3; p++)
    begin
      wr(`TPG_ADDR_A_DRIVE_EN + p, 8'h00);
      wr(`TPG_ADDR_A_OUT_LATCH + p, 8'hA5 + p[7:0]);
      rc(`TPG_ADDR_A_OUT_LATCH + p, 8'hA5 + p[7:0], 8'hFF);
      check(oe[p], 8'h00);
      wr(`TPG_ADDR_A_DRIVE_EN + p, 8'h3C);
      rc(`TPG_ADDR_A_DRIVE_EN + p, 8'h3C, 8'hFF);
      check(po[p] & 8'h3C, (8'hA5 + p[7:0]) & 8'h3C);
      check(oe[p], 8'h3C);
      rc(`TPG_ADDR_A_PIN_LEVELS + p, 8'hA5 + p[7:0], 8'h3C);
    end
  endtask
  task automatic t_alt();
    for (bit [15:0] p = 0; p < 3; p++)
    begin
      @(posedge clk_i);
      ao[p] <= 8'hC3;
      ae[p] <= 8'h0A;
      wr(`TPG_ADDR_A_ALT_SEL + p, 8'h0F);
      repeat (2) @(negedge clk_i);
      check(po[p], 8'h03 | ((8'hA5 + p[7:0]) & 8'hF0));
      check(oe[p], 8'h3A);
      rc(`TPG_ADDR_A_PIN_LEVELS + p, 8'h03 | ((8'hA5 + p[7:0]) & 8'hF0), 8'h3A);
    end
  endtask
  task automatic t_ro();
    for (bit [15:0] p = 0; p < 3; p++)
    begin
      wr(`TPG_ADDR_A_PIN_LEVELS + p, 8'h00);
      rc(`TPG_ADDR_A_OUT_LATCH + p, 8'hA5 + p[7:0], 8'hFF);
      rc(`TPG_ADDR_A_DRIVE_EN + p, 8'h3C, 8'hFF);
    end
    wr(16'h7F90, 8'hFF);
    rc(16'h7F90, 8'h00, 8'hFF);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_gpio();
    t_alt();
    t_ro();
    print_verdict();
  end
endmodule // three_port_gpio_block_test
